// ==== rtl/las_pkg.sv ====
package las_pkg;
  localparam int DW = 16;
  localparam int NEV = 5;
  localparam int NAL = 6;
  // register byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h04;
  localparam logic [7:0] REG_VPROT = 8'h08;
  localparam logic [7:0] REG_APROT = 8'h0C;
  localparam logic [7:0] REG_WPROT = 8'h10;
  localparam logic [7:0] REG_EVTHR0 = 8'h14;
  localparam logic [7:0] REG_EVACT = 8'h28;
  localparam logic [7:0] REG_STATUS = 8'h2C;
  localparam logic [7:0] REG_PROF = 8'h30;
  // control and command bit positions
  localparam int CTRL_SOUND = 0;
  localparam int CTRL_MSMODE = 1;
  localparam int CMD_ACK = 0;
  localparam int CMD_DCON = 1;
  localparam int CMD_DCOFF = 2;
  localparam int CMD_REINIT = 3;
  localparam int CMD_LOAD = 4;
  localparam int CMD_SAVE = 5;
  localparam int CMD_PIDX = 8;
  // status field positions
  localparam int ST_PEND = 0;
  localparam int ST_COND = 8;
  localparam int ST_EVFLAG = 16;
  localparam int ST_DCON = 24;
  // alarm indices
  localparam int AL_VOLT = 0;
  localparam int AL_AMP = 1;
  localparam int AL_WATT = 2;
  localparam int AL_SUPPLY = 3;
  localparam int AL_HEAT = 4;
  localparam int AL_LINK = 5;
  // event indices
  localparam int EV_LOWV = 0;
  localparam int EV_HIGHV = 1;
  localparam int EV_LOWA = 2;
  localparam int EV_HIGHA = 3;
  localparam int EV_HIGHW = 4;
  // event actions
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_SIGNAL = 2'h1;
  localparam logic [1:0] ACT_WARNING = 2'h2;
  localparam logic [1:0] ACT_ALARM = 2'h3;
  // protection defaults and ranges in percent of nominal
  localparam int PCT_VPROT = 103;
  localparam int PCT_APROT = 110;
  localparam int PCT_MAX = 110;
  localparam int PCT_EVW_MAX = 100;
  localparam int NOM_DEF = 16'h3E80;
  localparam int NPROF_DEF = 6;
  localparam int SYNC_W = 4;

  typedef struct packed {
    logic [DW-1:0] volt;
    logic [DW-1:0] amp;
    logic [DW-1:0] watt;
  } las_meas_t;

  typedef struct packed {
    logic [NEV-1:0][DW-1:0] thr;
    logic [NEV-1:0][1:0] act;
  } las_evcfg_t;

  // hardware alarm pins after synchronising
  typedef struct packed {
    logic slave_uninit;
    logic slave_lost;
    logic overheat;
    logic supply_fail;
  } las_hw_t;
endpackage : las_pkg

// ==== rtl/las_sync.sv ====
`timescale 1ns/1ns
module las_sync
  import las_pkg::*;
#(
  parameter int W = SYNC_W
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } las_sync_st_t;

  las_sync_st_t s_r;
  las_sync_st_t s_nxt;

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.s1 = d;
    s_nxt.s2 = s_r.s1;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign q = s_r.s2;
endmodule : las_sync

// ==== rtl/las_prof_store.sv ====
`timescale 1ns/1ns
module las_prof_store
  import las_pkg::*;
#(
  parameter int NPROF = NPROF_DEF
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // save port; slot 0 is the read-only default profile
  input wire logic wr_en,
  input wire logic [2:0] wr_idx,
  input wire las_evcfg_t wr_cfg,
  // load port
  input wire logic [2:0] rd_idx,
  output las_evcfg_t rd_cfg
);
  typedef struct packed {
    las_evcfg_t [NPROF-1:0] slot;
  } las_prof_st_t;

  las_prof_st_t s_r;
  las_prof_st_t s_nxt;

  always_comb
  begin
    s_nxt = s_r;
    if (wr_en && wr_idx != 3'h0 && int'(wr_idx) < NPROF)
    begin
      s_nxt.slot[wr_idx] = wr_cfg;
    end
  end

  // after reset every slot holds action none and zero thresholds
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign rd_cfg = (int'(rd_idx) < NPROF) ? s_r.slot[rd_idx] : '0;
endmodule : las_prof_store

// ==== rtl/las_supervisor.sv ====
// Behaviour
// - an alarm turns the input off, lights the indicator, beeps if sound enabled
// - every alarm except the link alarm stays pending until acknowledged
// - acknowledge with the cause gone removes the indication
// - acknowledge with the cause present keeps it; another acknowledge needed later
// - voltage at or above its threshold raises an alarm and turns input off
// - current at or above its threshold alarms; threshold up to 1.1 times nominal
// - power at or above its threshold alarms; threshold up to 1.1 times nominal
// - default thresholds are 103% voltage, 110% current and power
// - overheat holds the input off only while the heat condition lasts
// - master mode alarms and turns off on a lost or uninitialised slave
// - link alarm clears only by leaving master mode or reinitialising
// - a setting chooses whether alarms and alarm-action events beep
// - after reset all event actions are none
// - events are evaluated only while the input is on
// - each event has its own threshold and one of four actions
// - low voltage event fires when voltage is below its threshold
// - high voltage event fires when voltage exceeds its threshold
// - low current event fires when current is below its threshold
// - high current event fires when current exceeds its threshold
// - high power event fires above its threshold, limited to nominal power
// - an event with action alarm turns the input off
// - event settings live per profile; selecting a profile loads them
// - signal posts a message; warning adds a warning pop-up, input stays on
// - alarm action posts message, alarm pop-up, beeps if enabled, input off
`timescale 1ns/1ns
module las_supervisor
  import las_pkg::*;
#(
  parameter int V_NOM = NOM_DEF,
  parameter int I_NOM = NOM_DEF,
  parameter int P_NOM = NOM_DEF,
  parameter int NPROF = NPROF_DEF
)
(
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST,
  // register port
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WR_DATA,
  input wire logic WR_STB,
  input wire logic RD_STB,
  output logic [31:0] RD_DATA,
  // measurement samples
  input wire logic MEAS_VLD,
  input wire las_meas_t MEAS,
  // hardware alarm pins
  input wire logic SUPPLY_FAIL,
  input wire logic OVERHEAT,
  input wire logic SLAVE_LOST,
  input wire logic SLAVE_UNINIT,
  // indications
  output logic DC_ENABLE,
  output logic ALARM_LED,
  output logic BEEP,
  output logic STATUS_MSG,
  output logic WARN_POPUP,
  output logic ALARM_POPUP,
  output logic [NAL-1:0] ALARM_FLAGS
);
  localparam logic [DW-1:0] VPROT_DEF = DW'(V_NOM * PCT_VPROT / 100);
  localparam logic [DW-1:0] APROT_DEF = DW'(I_NOM * PCT_APROT / 100);
  localparam logic [DW-1:0] WPROT_DEF = DW'(P_NOM * PCT_APROT / 100);
  localparam logic [DW-1:0] AMAX = DW'(I_NOM * PCT_MAX / 100);
  localparam logic [DW-1:0] WMAX = DW'(P_NOM * PCT_MAX / 100);
  localparam logic [DW-1:0] EVW_MAX = DW'(P_NOM * PCT_EVW_MAX / 100);

  typedef struct packed {
    logic sound;
    logic ms_mode;
    logic [2:0] prof;
    logic [DW-1:0] thr_v;
    logic [DW-1:0] thr_a;
    logic [DW-1:0] thr_w;
    las_evcfg_t ev;
    logic [NAL-1:0] cond;
    logic [NAL-1:0] pend;
    logic [NEV-1:0] evflag;
    logic dc_on;
    logic led;
    logic beep;
    logic msg;
    logic warn;
    logic apop;
    logic [31:0] rdata;
  } las_core_st_t;

  las_core_st_t s_r;
  las_core_st_t s_nxt;
  las_hw_t hw;
  las_evcfg_t prof_cfg;
  logic [NEV-1:0] ev_trig;
  logic ev_trip;
  logic wr_cmd;
  logic ack;
  logic reinit;
  logic [DW-1:0] wval;

  // pins are asynchronous to the core clock
  las_sync #(
    .W(SYNC_W)
  ) u_sync (
    .clk(CORE_CLK),
    .rst(RST),
    .d({SLAVE_UNINIT, SLAVE_LOST, OVERHEAT, SUPPLY_FAIL}),
    .q(hw)
  );

  las_prof_store #(
    .NPROF(NPROF)
  ) u_prof (
    .clk(CORE_CLK),
    .rst(RST),
    .wr_en(wr_cmd && WR_DATA[CMD_SAVE]),
    .wr_idx(WR_DATA[CMD_PIDX +: 3]),
    .wr_cfg(s_r.ev),
    .rd_idx(WR_DATA[CMD_PIDX +: 3]),
    .rd_cfg(prof_cfg)
  );

  assign wr_cmd = WR_STB && ADDR == REG_CMD;
  assign ack = wr_cmd && WR_DATA[CMD_ACK];
  assign reinit = wr_cmd && WR_DATA[CMD_REINIT];
  assign wval = WR_DATA[DW-1:0];

  // event comparisons against the live sample
  always_comb
  begin
    ev_trig = '0;
    ev_trig[EV_LOWV] = MEAS.volt < s_r.ev.thr[EV_LOWV];
    ev_trig[EV_HIGHV] = MEAS.volt > s_r.ev.thr[EV_HIGHV];
    ev_trig[EV_LOWA] = MEAS.amp < s_r.ev.thr[EV_LOWA];
    ev_trig[EV_HIGHA] = MEAS.amp > s_r.ev.thr[EV_HIGHA];
    ev_trig[EV_HIGHW] = MEAS.watt > s_r.ev.thr[EV_HIGHW];
  end

  always_comb
  begin
    s_nxt = s_r;
    ev_trip = 1'b0;
    s_nxt.rdata = '0;
    // register writes
    if (WR_STB)
    begin
      case (ADDR)
        REG_CTRL:
        begin
          s_nxt.sound = WR_DATA[CTRL_SOUND];
          s_nxt.ms_mode = WR_DATA[CTRL_MSMODE];
        end
        REG_VPROT: s_nxt.thr_v = wval;
        REG_APROT: s_nxt.thr_a = (wval > AMAX) ? AMAX : wval;
        REG_WPROT: s_nxt.thr_w = (wval > WMAX) ? WMAX : wval;
        REG_EVACT: s_nxt.ev.act = WR_DATA[2*NEV-1:0];
        default:
        begin
        end
      endcase
      for (int i = 0; i < NEV; i++)
      begin
        if (ADDR == REG_EVTHR0 + 8'(4 * i))
        begin
          s_nxt.ev.thr[i] = wval;
        end
      end
      if (ADDR == REG_EVTHR0 + 8'(4 * EV_HIGHW) && wval > EVW_MAX)
      begin
        s_nxt.ev.thr[EV_HIGHW] = EVW_MAX;
      end
    end
    // a profile switch replaces the whole working event set
    if (wr_cmd && WR_DATA[CMD_LOAD] && int'(WR_DATA[CMD_PIDX +: 3]) < NPROF)
    begin
      s_nxt.ev = prof_cfg;
      s_nxt.prof = WR_DATA[CMD_PIDX +: 3];
    end
    // voltage, current and power conditions refresh only on a new sample; pin conditions every cycle
    if (MEAS_VLD)
    begin
      s_nxt.cond[AL_VOLT] = MEAS.volt >= s_r.thr_v;
      s_nxt.cond[AL_AMP] = MEAS.amp >= s_r.thr_a;
      s_nxt.cond[AL_WATT] = MEAS.watt >= s_r.thr_w;
    end
    s_nxt.cond[AL_SUPPLY] = hw.supply_fail;
    s_nxt.cond[AL_HEAT] = hw.overheat;
    s_nxt.cond[AL_LINK] = s_r.ms_mode && (hw.slave_lost || hw.slave_uninit);
    // acknowledge clears only causes already gone; a live cause wins
    for (int i = 0; i < AL_LINK; i++)
    begin
      if (ack && !s_nxt.cond[i])
      begin
        s_nxt.pend[i] = 1'b0;
      end
      if (s_nxt.cond[i])
      begin
        s_nxt.pend[i] = 1'b1;
      end
    end
    // link alarm ignores acknowledge
    if (!s_r.ms_mode || reinit)
    begin
      s_nxt.pend[AL_LINK] = 1'b0;
    end
    if (s_nxt.cond[AL_LINK])
    begin
      s_nxt.pend[AL_LINK] = 1'b1;
    end
    // events: sticky flags, set wins over acknowledge
    if (ack)
    begin
      s_nxt.evflag = '0;
    end
    if (MEAS_VLD && s_r.dc_on)
    begin
      for (int i = 0; i < NEV; i++)
      begin
        if (ev_trig[i] && s_r.ev.act[i] != ACT_NONE)
        begin
          s_nxt.evflag[i] = 1'b1;
          if (s_r.ev.act[i] == ACT_ALARM)
          begin
            ev_trip = 1'b1;
          end
        end
      end
    end
    // input switching: any live cause holds it off, so overheat releases by itself
    if (wr_cmd && WR_DATA[CMD_DCOFF])
    begin
      s_nxt.dc_on = 1'b0;
    end
    else if (wr_cmd && WR_DATA[CMD_DCON])
    begin
      s_nxt.dc_on = 1'b1;
    end
    if ((|s_nxt.cond) || ev_trip)
    begin
      s_nxt.dc_on = 1'b0;
    end
    // indications
    s_nxt.led = |s_nxt.pend;
    s_nxt.msg = |s_nxt.evflag;
    s_nxt.warn = 1'b0;
    s_nxt.apop = 1'b0;
    for (int i = 0; i < NEV; i++)
    begin
      if (s_nxt.evflag[i] && s_nxt.ev.act[i] == ACT_WARNING)
      begin
        s_nxt.warn = 1'b1;
      end
      if (s_nxt.evflag[i] && s_nxt.ev.act[i] == ACT_ALARM)
      begin
        s_nxt.apop = 1'b1;
      end
    end
    s_nxt.beep = s_nxt.sound && (s_nxt.led || s_nxt.apop);
    // register reads, answer only in the following cycle
    if (RD_STB)
    begin
      case (ADDR)
        REG_CTRL: s_nxt.rdata = 32'({s_r.ms_mode, s_r.sound});
        REG_VPROT: s_nxt.rdata = 32'(s_r.thr_v);
        REG_APROT: s_nxt.rdata = 32'(s_r.thr_a);
        REG_WPROT: s_nxt.rdata = 32'(s_r.thr_w);
        REG_EVACT: s_nxt.rdata = 32'(s_r.ev.act);
        REG_PROF: s_nxt.rdata = 32'(s_r.prof);
        REG_STATUS:
        begin
          s_nxt.rdata[ST_PEND +: NAL] = s_r.pend;
          s_nxt.rdata[ST_COND +: NAL] = s_r.cond;
          s_nxt.rdata[ST_EVFLAG +: NEV] = s_r.evflag;
          s_nxt.rdata[ST_DCON] = s_r.dc_on;
        end
        default:
        begin
          for (int i = 0; i < NEV; i++)
          begin
            if (ADDR == REG_EVTHR0 + 8'(4 * i))
            begin
              s_nxt.rdata = 32'(s_r.ev.thr[i]);
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      s_r <= '0;
      s_r.thr_v <= VPROT_DEF;
      s_r.thr_a <= APROT_DEF;
      s_r.thr_w <= WPROT_DEF;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign RD_DATA = s_r.rdata;
  assign DC_ENABLE = s_r.dc_on;
  assign ALARM_LED = s_r.led;
  assign BEEP = s_r.beep;
  assign STATUS_MSG = s_r.msg;
  assign WARN_POPUP = s_r.warn;
  assign ALARM_POPUP = s_r.apop;
  assign ALARM_FLAGS = s_r.pend;

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RST);

  sequence volt_over_s;
    MEAS_VLD && MEAS.volt >= s_r.thr_v;
  endsequence

  sequence ev_alarm_s;
    MEAS_VLD && s_r.dc_on && ev_trig[EV_HIGHA] && s_r.ev.act[EV_HIGHA] == ACT_ALARM;
  endsequence

  volt_trip_a:
    assert property (volt_over_s |=> !DC_ENABLE && s_r.pend[AL_VOLT] && ALARM_LED)
    else $error("voltage over threshold did not trip the input");

  cause_off_a:
    assert property ((|s_r.cond) |-> !DC_ENABLE)
    else $error("input on while an alarm cause is present");

  pend_hold_a:
    assert property (s_r.pend[AL_AMP] && !ack |=> s_r.pend[AL_AMP])
    else $error("alarm dropped without acknowledge");

  ack_clear_a:
    assert property (ack && !s_nxt.cond[AL_WATT] |=> !s_r.pend[AL_WATT])
    else $error("acknowledge did not clear a vanished alarm");

  ack_keep_a:
    assert property (ack && s_nxt.cond[AL_HEAT] |=> s_r.pend[AL_HEAT] && ALARM_LED)
    else $error("acknowledge cleared a present alarm");

  link_hold_a:
    assert property (s_r.pend[AL_LINK] && s_r.ms_mode && !reinit |=> s_r.pend[AL_LINK])
    else $error("link alarm cleared without leaving master mode");

  thr_range_a:
    assert property (s_r.thr_a <= AMAX && s_r.thr_w <= WMAX)
    else $error("protection threshold above its range");

  ev_idle_a:
    assert property (!s_r.dc_on && !ack |=> $stable(s_r.evflag))
    else $error("event evaluated while input off");

  ev_trip_a:
    assert property (ev_alarm_s |=> !DC_ENABLE && ALARM_POPUP)
    else $error("alarm action did not turn the input off");

  beep_gate_a:
    assert property (BEEP |-> s_r.sound)
    else $error("beep without sound enabled");

  warn_on_a:
    assert property (MEAS_VLD && s_r.dc_on && ev_trig[EV_LOWV]
                     && s_r.ev.act[EV_LOWV] == ACT_WARNING && !(|s_nxt.cond)
                     && !ev_trip && !(wr_cmd && WR_DATA[CMD_DCOFF])
                     |=> DC_ENABLE && WARN_POPUP && STATUS_MSG)
    else $error("warning action wrong");
endmodule : las_supervisor

// ==== testbench/las_dc_source.sv ====
`timescale 1ns/1ns
module las_dc_source
  import las_pkg::*;
#(
  parameter int PERIOD = 4
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // load state and source setting
  input wire logic dc_on,
  input wire las_meas_t src_set,
  // measurement path
  output logic meas_vld,
  output las_meas_t meas
);
  int cnt;

  // an open load input draws nothing, but the source voltage stays up
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt <= 0;
      meas_vld <= 1'b0;
      meas <= '0;
    end
    else
    begin
      cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      meas_vld <= (cnt == 0);
      if (cnt == 0)
      begin
        meas.volt <= src_set.volt;
        meas.amp <= dc_on ? src_set.amp : '0;
        meas.watt <= dc_on ? src_set.watt : '0;
      end
      else
      begin
        meas <= ~meas; // not valid between samples, so keep it moving
      end
    end
  end
endmodule : las_dc_source

// ==== testbench/test_las_supervisor.sv ====
`timescale 1ns/1ns
module test_las_supervisor
  import las_pkg::*;
;
  localparam int NOM = 1000;
  logic clk, rst, wr_stb, rd_stb, meas_vld, dc_on, led, beep, msg, warn, apop;
  logic [7:0] addr;
  logic [31:0] wr_data, rd_data, seed, d;
  logic [15:0] v;
  // supply, heat, slave lost, slave uninitialised
  logic [3:0] pins;
  logic [NAL-1:0] flags;
  las_meas_t meas, src_set;
  int err_count, check_count, cycles;

  las_dc_source i_las_dc_source (.clk(clk), .rst(rst), .dc_on(dc_on), .src_set(src_set),
    .meas_vld(meas_vld), .meas(meas));

  las_supervisor #(.V_NOM(NOM), .I_NOM(NOM), .P_NOM(NOM), .NPROF(NPROF_DEF)) i_las_supervisor (
    .CORE_CLK(clk), .RST(rst), .ADDR(addr), .WR_DATA(wr_data), .WR_STB(wr_stb),
    .RD_STB(rd_stb), .RD_DATA(rd_data), .MEAS_VLD(meas_vld), .MEAS(meas),
    .SUPPLY_FAIL(pins[0]), .OVERHEAT(pins[1]), .SLAVE_LOST(pins[2]), .SLAVE_UNINIT(pins[3]),
    .DC_ENABLE(dc_on), .ALARM_LED(led), .BEEP(beep), .STATUS_MSG(msg), .WARN_POPUP(warn),
    .ALARM_POPUP(apop), .ALARM_FLAGS(flags));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic logic [31:0] pct(input int p);
    return NOM * p / 100;
  endfunction : pct

  task final_report;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : final_report

  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [31:0] x);
    @(posedge clk);
    addr <= a;
    wr_data <= x;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a, output logic [31:0] x);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 x = rd_data;
  endtask : rd

  task cmd(input int b);
    wr(REG_CMD, 32'h0000_0001 << b);
  endtask : cmd

  task waitc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : waitc

  task pin(input int j, input logic b);
    @(posedge clk);
    pins[j] <= b;
  endtask : pin

  // all fields at base, field k at x
  task setf(input int k, input logic [15:0] base, input logic [15:0] x);
    las_meas_t m;
    m = {base, base, base};
    m[47-16*k -: 16] = x;
    @(posedge clk);
    src_set <= m;
  endtask : setf

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_count++;
      $display("wrong value at %0t: run hangs", $time);
      final_report();
    end
  end

  initial
  begin
    rst = 1'b1;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    addr = '0;
    wr_data = '0;
    pins = '0;
    src_set = '0;
    seed = 32'h0000_65b7;
    err_count = 0;
    check_count = 0;
    cycles = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd(REG_VPROT, d); chk(d, pct(PCT_VPROT), "volt thr");
    rd(REG_APROT, d); chk(d, pct(PCT_APROT), "amp thr");
    rd(REG_WPROT, d); chk(d, pct(PCT_APROT), "watt thr");
    rd(REG_EVACT, d); chk(d, 0, "actions");
    rd(8'h3C, d); chk(d, 0, "unmapped");
    wr(REG_APROT, 32'h0000_FFFF); rd(REG_APROT, d); chk(d, pct(PCT_MAX), "amp max");
    wr(REG_WPROT, 32'h0000_FFFF); rd(REG_WPROT, d); chk(d, pct(PCT_MAX), "watt max");
    wr(REG_EVTHR0 + 8'h10, 32'h0000_FFFF);
    rd(REG_EVTHR0 + 8'h10, d); chk(d, pct(PCT_EVW_MAX), "event watt max");
    wr(REG_APROT, pct(PCT_APROT));
    wr(REG_WPROT, pct(PCT_APROT));
    $display("test reset done");
    wr(REG_CTRL, 32'h0000_0001);
    for (int k = 0; k < 3; k++)
    begin
      seed = lfsr(seed);
      v = 16'h00C8 + 16'(seed % 800);
      wr(REG_VPROT + 8'(4 * k), {16'h0000, v});
      setf(k, 16'h0064, 16'h0064);
      cmd(CMD_DCON); waitc(10);
      setf(k, 16'h0064, v); waitc(10);
      chk(flags, 32'h0000_0001 << k, "protect flag");
      chk({led, beep, dc_on}, 3'b110, "alarm indications");
      cmd(CMD_ACK); waitc(2);
      chk(flags[k], k == 0, "ack with cause");
      setf(k, 16'h0064, v - 16'h0001); waitc(10);
      chk(flags[k], k == 0, "held pending");
      cmd(CMD_ACK); waitc(2);
      chk({flags[k], led, beep}, 0, "cleared");
      wr(REG_VPROT + 8'(4 * k), k == 0 ? pct(PCT_VPROT) : pct(PCT_APROT));
    end
    $display("test protection done");
    for (int j = 0; j < 2; j++)
    begin
      cmd(CMD_DCON); waitc(2);
      pin(j, 1'b1); waitc(6);
      chk({flags, dc_on}, {6'h01 << (3 + j), 1'b0}, "pin alarm");
      rd(REG_STATUS, d); chk(d, 32'h0000_0808 << j, "status");
      cmd(CMD_DCON); waitc(2); chk(dc_on, 0, "on refused");
      pin(j, 1'b0); waitc(6);
      cmd(CMD_DCON); waitc(2);
      chk({dc_on, flags[3 + j]}, 2'b11, "on again, pending");
      cmd(CMD_ACK); waitc(2); chk(flags, 0, "pin cleared");
    end
    wr(REG_CTRL, 32'h0000_0003);
    rd(REG_CTRL, d); chk(d, 32'h0000_0003, "control");
    cmd(CMD_DCON); waitc(2);
    pin(2, 1'b1); waitc(6); chk({flags[AL_LINK], dc_on}, 2'b10, "slave lost");
    pin(2, 1'b0); waitc(6); cmd(CMD_ACK); waitc(2);
    chk(flags[AL_LINK], 1, "ack no effect");
    cmd(CMD_REINIT); waitc(2); chk(flags[AL_LINK], 0, "reinit");
    pin(3, 1'b1); waitc(6); chk(flags[AL_LINK], 1, "slave uninit");
    pin(3, 1'b0); wr(REG_CTRL, 32'h0000_0001); waitc(2);
    chk(flags[AL_LINK], 0, "mode off");
    $display("test pins done");
    for (int e = 0; e < NEV; e++)
      wr(REG_EVTHR0 + 8'(4 * e), 32'h0000_01F4);
    for (int e = 0; e < NEV; e++)
      for (int a = 1; a < 4; a++)
      begin
        setf(e / 2, 16'h01F4, 16'h01F4);
        // a sample taken just before switch-on still reads zero current
        wr(REG_EVACT, 32'h0000_0000);
        cmd(CMD_DCON); waitc(10);
        wr(REG_EVACT, 32'(a) << (2 * e));
        cmd(CMD_ACK); waitc(2);
        seed = lfsr(seed);
        v = (e == 0 || e == 2) ? 16'h01F3 - 16'(seed % 100) : 16'h01F5 + 16'(seed % 100);
        setf(e / 2, 16'h01F4, v); waitc(10);
        chk({msg, warn, apop, dc_on, beep}, {1'b1, a == 2, a == 3, a != 3, a == 3},
          "event actions");
        setf(e / 2, 16'h01F4, 16'h01F4); waitc(10);
        chk(msg, 1, "event latched");
        cmd(CMD_ACK); waitc(2); chk(msg, 0, "event acked");
      end
    wr(REG_EVACT, 32'h0000_0155);
    cmd(CMD_DCOFF);
    setf(0, 16'h01F4, 16'h0064); waitc(10); chk(msg, 0, "input off");
    cmd(CMD_DCON); waitc(10); chk(msg, 1, "input on");
    $display("test events done");
    wr(REG_EVACT, 32'h0000_02E4);
    wr(REG_CMD, 32'h0000_0220);
    wr(REG_EVACT, 32'h0000_0000);
    wr(REG_CMD, 32'h0000_0210);
    rd(REG_EVACT, d); chk(d, 32'h0000_02E4, "loaded actions");
    rd(REG_PROF, d); chk(d, 32'h0000_0002, "active profile");
    wr(REG_CMD, 32'h0000_0010);
    rd(REG_EVACT, d); chk(d, 0, "default profile");
    wr(REG_CTRL, 32'h0000_0000);
    pin(1, 1'b1); waitc(6); chk({led, beep}, 2'b10, "silent alarm");
    pin(1, 1'b0);
    $display("test profile and sound done");
    final_report();
  end
endmodule : test_las_supervisor
